// File: pkg/tbc_params.svh
`ifndef TBC_PARAMS_SVH
`define TBC_PARAMS_SVH
// ---------------------------------------------
// Register byte addresses
// ---------------------------------------------
`define TBC_ADDR_CONTROL 12'h000
`define TBC_ADDR_MODE 12'h004
`define TBC_ADDR_COUNT_LOW 12'h008
`define TBC_ADDR_COUNT_HIGH 12'h00c
`define TBC_ADDR_RELOAD_LOW 12'h010
`define TBC_ADDR_RELOAD_HIGH 12'h014
`define TBC_ADDR_IRQ_ENABLE 12'h018
`define TBC_ADDR_IRQ_STATUS 12'h01c
// ---------------------------------------------
// Control and mode register fields
// ---------------------------------------------
`define TBC_CTL_OVF 7
`define TBC_CTL_EXF 6
`define TBC_CTL_RXSEL 5
`define TBC_CTL_TXSEL 4
`define TBC_CTL_EXEN 3
`define TBC_CTL_RUN 2
`define TBC_CTL_CNT 1
`define TBC_CTL_CAP 0
`define TBC_MODE_OE 1
`define TBC_MODE_DCEN 0
// ---------------------------------------------
// Enable register fields
// ---------------------------------------------
`define TBC_IE_GLOBAL 7
`define TBC_IE_RSVD 6
`define TBC_IE_T2 5
`define TBC_IE_SER 4
`define TBC_IE_T1 3
`define TBC_IE_X1 2
`define TBC_IE_T0 1
`define TBC_IE_X0 0
`define TBC_IE_WMASK 8'hbf
// ---------------------------------------------
// Reset values and timing
// ---------------------------------------------
`define TBC_RST_BYTE 8'h00
`define TBC_RST_MODE 8'h00
`define TBC_STATE_DIV 3'h1
`define TBC_MACH_DIV 4'hb
`define TBC_BAUD_DIV 4'hf
`endif

// File: pkg/tbc_pkg.sv
package tbc_pkg;
  typedef enum logic [1:0] {
    TBC_OFF = 2'b00,
    TBC_RELOAD = 2'b01,
    TBC_CAPTURE = 2'b10,
    TBC_BAUD = 2'b11
  } tbc_mode_t;
endpackage

// File: hdl/tbc_timer2.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "tbc_params.svh"
module tbc_timer2
  import tbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_trigger_pin,
  input wire logic count_pin_in,
  input wire logic external_irq_zero_pin,
  input wire logic external_irq_one_pin,
  input wire logic tmr_zero_ovf_flag,
  input wire logic tmr_one_ovf_flag,
  input wire logic serial_port_irq,
  output logic clock_out_port_bit,
  output logic clock_out_port_bit_oe,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic [5:0] irq_request
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] mode;
    logic [15:0] count;
    logic [15:0] reload;
    logic [7:0] ie;
    logic [3:0] prescale;
    logic [3:0] rx_div;
    logic [3:0] tx_div;
    logic clk_out;
    logic rx_tick;
    logic tx_tick;
    logic [2:0] trig_sync;
    logic trig_last;
    logic [2:0] cnt_sync;
    logic cnt_last;
    logic [31:0] rdata;
  } tbc_state_t;

  tbc_state_t st_reg;
  tbc_state_t st_next;
  tbc_mode_t mode_sel;
  logic baud_mode;
  logic clkout_mode;
  logic tick;
  logic rollover;
  logic trig_fall;
  logic cnt_fall;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_val;

  // ---------------------------------------------
  // Mode decode
  // ---------------------------------------------
  assign baud_mode = st_reg.ctl[`TBC_CTL_RXSEL] | st_reg.ctl[`TBC_CTL_TXSEL];
  assign clkout_mode = ~st_reg.ctl[`TBC_CTL_CNT] & st_reg.mode[`TBC_MODE_OE];

  always_comb
  begin
    if (!st_reg.ctl[`TBC_CTL_RUN])
      mode_sel = TBC_OFF;
    else if (baud_mode)
      mode_sel = TBC_BAUD;
    else if (st_reg.ctl[`TBC_CTL_CAP])
      mode_sel = TBC_CAPTURE;
    else
      mode_sel = TBC_RELOAD;
  end

  // Filtered edges: second and third sync stages must agree
  assign trig_fall = (st_reg.trig_sync[2] == st_reg.trig_sync[1]) & ~st_reg.trig_sync[2] & st_reg.trig_last;
  assign cnt_fall = (st_reg.cnt_sync[2] == st_reg.cnt_sync[1]) & ~st_reg.cnt_sync[2] & st_reg.cnt_last;

  // ---------------------------------------------
  // Bus decode
  // ---------------------------------------------
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `TBC_ADDR_IRQ_STATUS);
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = st_reg.rdata;

  always_comb
  begin
    case (paddr)
      `TBC_ADDR_CONTROL: rd_val = {24'h000000, st_reg.ctl};
      `TBC_ADDR_MODE: rd_val = {24'h000000, 6'h00, st_reg.mode[1:0]};
      `TBC_ADDR_COUNT_LOW: rd_val = {24'h000000, st_reg.count[7:0]};
      `TBC_ADDR_COUNT_HIGH: rd_val = {24'h000000, st_reg.count[15:8]};
      `TBC_ADDR_RELOAD_LOW: rd_val = {24'h000000, st_reg.reload[7:0]};
      `TBC_ADDR_RELOAD_HIGH: rd_val = {24'h000000, st_reg.reload[15:8]};
      `TBC_ADDR_IRQ_ENABLE: rd_val = {24'h000000, st_reg.ie};
      `TBC_ADDR_IRQ_STATUS: rd_val = {26'h0, irq_request};
      default: rd_val = 32'h00000000;
    endcase
  end

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.rx_tick = 1'b0;
    st_next.tx_tick = 1'b0;
    st_next.trig_sync = {st_reg.trig_sync[1:0], external_trigger_pin};
    st_next.cnt_sync = {st_reg.cnt_sync[1:0], count_pin_in};
    if (st_reg.trig_sync[2] == st_reg.trig_sync[1])
      st_next.trig_last = st_reg.trig_sync[2];
    if (st_reg.cnt_sync[2] == st_reg.cnt_sync[1])
      st_next.cnt_last = st_reg.cnt_sync[2];
    tick = 1'b0;
    rollover = 1'b0;
    if (rd_en)
      st_next.rdata = rd_val;
    // Software writes first so a same-cycle hardware set wins
    if (wr_en && addr_ok)
    begin
      case (paddr)
        `TBC_ADDR_CONTROL: st_next.ctl = pwdata[7:0];
        `TBC_ADDR_MODE: st_next.mode = {6'h00, pwdata[1:0]};
        `TBC_ADDR_COUNT_LOW: st_next.count[7:0] = pwdata[7:0];
        `TBC_ADDR_COUNT_HIGH: st_next.count[15:8] = pwdata[7:0];
        `TBC_ADDR_RELOAD_LOW: st_next.reload[7:0] = pwdata[7:0];
        `TBC_ADDR_RELOAD_HIGH: st_next.reload[15:8] = pwdata[7:0];
        `TBC_ADDR_IRQ_ENABLE: st_next.ie = pwdata[7:0] & `TBC_IE_WMASK;
        default: st_next.ie = st_next.ie;
      endcase
    end
    // Prescaler: count pin falls in counter mode outside baud, state time in baud or clock out, machine cycle otherwise
    if (mode_sel != TBC_OFF)
    begin
      if (st_reg.ctl[`TBC_CTL_CNT] && !baud_mode)
        tick = cnt_fall;
      else if (baud_mode || clkout_mode)
      begin
        tick = (st_reg.prescale >= {1'b0, `TBC_STATE_DIV});
        st_next.prescale = tick ? 4'h0 : st_reg.prescale + 4'h1;
      end
      else
      begin
        tick = (st_reg.prescale >= `TBC_MACH_DIV);
        st_next.prescale = tick ? 4'h0 : st_reg.prescale + 4'h1;
      end
    end
    else
      st_next.prescale = 4'h0;
    if (tick)
    begin
      rollover = (st_reg.count == 16'hffff);
      st_next.count = rollover ? st_reg.reload : st_reg.count + 16'h0001;
    end
    // Overflow flag only outside baud and clock out
    if (rollover && !baud_mode && !clkout_mode)
      st_next.ctl[`TBC_CTL_OVF] = 1'b1;
    if (rollover && clkout_mode)
      st_next.clk_out = ~st_reg.clk_out;
    if (!clkout_mode)
      st_next.clk_out = 1'b0;
    // Baud ticks: overflow divided by 16 per direction
    if (rollover && st_reg.ctl[`TBC_CTL_RXSEL])
    begin
      st_next.rx_div = st_reg.rx_div + 4'h1;
      st_next.rx_tick = (st_reg.rx_div == `TBC_BAUD_DIV);
    end
    if (rollover && st_reg.ctl[`TBC_CTL_TXSEL])
    begin
      st_next.tx_div = st_reg.tx_div + 4'h1;
      st_next.tx_tick = (st_reg.tx_div == `TBC_BAUD_DIV);
    end
    // External edge: flag always, reload or capture only outside baud mode
    if (trig_fall && st_reg.ctl[`TBC_CTL_EXEN])
    begin
      st_next.ctl[`TBC_CTL_EXF] = 1'b1;
      if (mode_sel == TBC_RELOAD)
        st_next.count = st_reg.reload;
      else if (mode_sel == TBC_CAPTURE)
        st_next.reload = st_reg.count;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.trig_sync <= 3'h7;
      st_reg.trig_last <= 1'b1;
      st_reg.cnt_sync <= 3'h7;
      st_reg.cnt_last <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign clock_out_port_bit = st_reg.clk_out;
  assign clock_out_port_bit_oe = clkout_mode;
  assign rx_baud_tick = st_reg.rx_tick;
  assign tx_baud_tick = st_reg.tx_tick;

  // Requests gated by the global enable; timer zero and one flags come in registered
  always_comb
  begin
    irq_request = 6'h00;
    if (st_reg.ie[`TBC_IE_GLOBAL])
    begin
      irq_request[0] = st_reg.ie[`TBC_IE_X0] & external_irq_zero_pin;
      irq_request[1] = st_reg.ie[`TBC_IE_T0] & tmr_zero_ovf_flag;
      irq_request[2] = st_reg.ie[`TBC_IE_X1] & external_irq_one_pin;
      irq_request[3] = st_reg.ie[`TBC_IE_T1] & tmr_one_ovf_flag;
      irq_request[4] = st_reg.ie[`TBC_IE_SER] & serial_port_irq;
      irq_request[5] = st_reg.ie[`TBC_IE_T2] & (st_reg.ctl[`TBC_CTL_OVF] | st_reg.ctl[`TBC_CTL_EXF]);
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  property p_baud_no_ovf;
    @(posedge pclk) disable iff (!presetn)
    (baud_mode && rollover && !st_reg.ctl[`TBC_CTL_OVF] && !(wr_en && paddr == `TBC_ADDR_CONTROL))
    |=> !st_reg.ctl[`TBC_CTL_OVF];
  endproperty
  a_baud_no_ovf: assert property (p_baud_no_ovf) else $error("Overflow flag set in baud mode");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    (rollover && !(wr_en && paddr[4:3] == 2'b01)) |=> (st_reg.count == $past(st_reg.reload));
  endproperty
  a_reload: assert property (p_reload) else $error("Rollover did not reload");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    (!st_reg.ctl[`TBC_CTL_RUN] && !wr_en && !trig_fall) |=> $stable(st_reg.count);
  endproperty
  a_stop: assert property (p_stop) else $error("Count moved while stopped");

  property p_state_rate;
    @(posedge pclk) disable iff (!presetn)
    (baud_mode && st_reg.ctl[`TBC_CTL_RUN] && tick) |=> !tick ##1 (tick || !st_reg.ctl[`TBC_CTL_RUN] || !baud_mode);
  endproperty
  a_state_rate: assert property (p_state_rate) else $error("Baud mode tick not every state time");

  property p_exf_set;
    @(posedge pclk) disable iff (!presetn)
    (trig_fall && st_reg.ctl[`TBC_CTL_EXEN]) |=> st_reg.ctl[`TBC_CTL_EXF];
  endproperty
  a_exf_set: assert property (p_exf_set) else $error("External flag not set");

  property p_baud_no_ext_reload;
    @(posedge pclk) disable iff (!presetn)
    (baud_mode && trig_fall && !tick && !wr_en) |=> $stable(st_reg.count);
  endproperty
  a_baud_no_ext_reload: assert property (p_baud_no_ext_reload) else $error("Trigger reloaded in baud mode");

  property p_global;
    @(posedge pclk) disable iff (!presetn)
    !st_reg.ie[`TBC_IE_GLOBAL] |-> (irq_request == 6'h00);
  endproperty
  a_global: assert property (p_global) else $error("Request with global enable off");

  property p_t2_or;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.ie[`TBC_IE_GLOBAL] && st_reg.ie[`TBC_IE_T2]) |->
    (irq_request[5] == (st_reg.ctl[`TBC_CTL_OVF] | st_reg.ctl[`TBC_CTL_EXF]));
  endproperty
  a_t2_or: assert property (p_t2_or) else $error("Timer two request mismatch");

  property p_clkout_toggle;
    @(posedge pclk) disable iff (!presetn)
    (clkout_mode && rollover && !wr_en) |=> (clock_out_port_bit != $past(clock_out_port_bit));
  endproperty
  a_clkout_toggle: assert property (p_clkout_toggle) else $error("Clock out did not toggle");

  property p_rsvd;
    @(posedge pclk) disable iff (!presetn)
    !st_reg.ie[`TBC_IE_RSVD];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved enable bit set");

  // Stopping the timer ends the tick train, so a stop inside the window is allowed
  property p_mach_rate;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.ctl[`TBC_CTL_RUN] && !baud_mode && !clkout_mode && !st_reg.ctl[`TBC_CTL_CNT] && tick)
    |=> (!tick) [*8] ##4 (tick || !st_reg.ctl[`TBC_CTL_RUN]);
  endproperty
  a_mach_rate: assert property (p_mach_rate) else $error("Timer tick not every machine cycle");

  property p_ovf_set;
    @(posedge pclk) disable iff (!presetn)
    (rollover && !baud_mode && !clkout_mode) |=> st_reg.ctl[`TBC_CTL_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("Overflow flag not set on rollover");

  property p_clkout_no_ovf;
    @(posedge pclk) disable iff (!presetn)
    (clkout_mode && rollover && !st_reg.ctl[`TBC_CTL_OVF] && !(wr_en && paddr == `TBC_ADDR_CONTROL))
    |=> !st_reg.ctl[`TBC_CTL_OVF];
  endproperty
  a_clkout_no_ovf: assert property (p_clkout_no_ovf) else $error("Overflow flag set in clock out mode");

  property p_exf_hold;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.ctl[`TBC_CTL_EXF] && !(wr_en && paddr == `TBC_ADDR_CONTROL)) |=> st_reg.ctl[`TBC_CTL_EXF];
  endproperty
  a_exf_hold: assert property (p_exf_hold) else $error("External flag cleared by hardware");

  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
    (tick && !rollover && !wr_en && !trig_fall) |=> (st_reg.count == $past(st_reg.count) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("Count did not advance on tick");

  property p_rx_pulse;
    @(posedge pclk) disable iff (!presetn)
    rx_baud_tick |=> !rx_baud_tick;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("Receive tick longer than one cycle");

  property p_tx_pulse;
    @(posedge pclk) disable iff (!presetn)
    tx_baud_tick |=> !tx_baud_tick;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("Transmit tick longer than one cycle");

  property p_clkout_idle;
    @(posedge pclk) disable iff (!presetn)
    !clkout_mode |=> !clock_out_port_bit;
  endproperty
  a_clkout_idle: assert property (p_clkout_idle) else $error("Port clock active outside clock out mode");
endmodule // tbc_timer2

// File: tb/tbc_serial_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Serial port side: watches baud ticks and the port clock
// ---------------------------------------------
module tbc_serial_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  input wire logic clock_out_port_bit,
  output logic [31:0] tx_gap,
  output logic [31:0] clk_gap,
  output logic [31:0] rx_count
);
  logic [31:0] now_reg;
  logic [31:0] tx_last;
  logic [31:0] clk_last;
  logic clk_prev;
  // Gaps are measured from tick to tick, so the first gap after start is junk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      now_reg <= 32'h0;
      tx_last <= 32'h0;
      clk_last <= 32'h0;
      clk_prev <= 1'b0;
      tx_gap <= 32'h0;
      clk_gap <= 32'h0;
      rx_count <= 32'h0;
    end
    else
    begin
      now_reg <= now_reg + 32'h1;
      clk_prev <= clock_out_port_bit;
      if (tx_baud_tick)
      begin
        tx_gap <= now_reg - tx_last;
        tx_last <= now_reg;
      end
      if (rx_baud_tick)
        rx_count <= rx_count + 32'h1;
      if (clock_out_port_bit != clk_prev)
      begin
        clk_gap <= now_reg - clk_last;
        clk_last <= now_reg;
      end
    end
  end
endmodule // tbc_serial_model

// File: tb/tb.sv
`timescale 1ns/1ps
`include "tbc_params.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trig = 1'b1;
  logic cnt_pin = 1'b1;
  logic [4:0] src = 5'h00;
  logic clk_out;
  logic clk_oe;
  logic rx_tick;
  logic tx_tick;
  logic [5:0] irq_request;
  logic [31:0] tx_gap;
  logic [31:0] clk_gap;
  logic [31:0] rx_count;
  logic serr;
  int mismatches = 0;
  int total_checks = 0;
  always #2.5 pclk = ~pclk;
  tbc_timer2 DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_trigger_pin(trig), .count_pin_in(cnt_pin), .external_irq_zero_pin(src[0]),
    .tmr_zero_ovf_flag(src[1]), .external_irq_one_pin(src[2]), .tmr_one_ovf_flag(src[3]),
    .serial_port_irq(src[4]), .clock_out_port_bit(clk_out), .clock_out_port_bit_oe(clk_oe),
    .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick), .irq_request(irq_request));
  tbc_serial_model u_ser (.pclk(pclk), .presetn(presetn), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
    .clock_out_port_bit(clk_out), .tx_gap(tx_gap), .clk_gap(clk_gap), .rx_count(rx_count));
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      mismatches++;
      end_sim();
    end
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task t_reset_map;
    rd(`TBC_ADDR_CONTROL, 32'h0);
    rd(`TBC_ADDR_MODE, 32'h0);
    rd(`TBC_ADDR_IRQ_ENABLE, 32'h0);
    rd(12'h020, 32'h0);
    chk({31'h0, serr}, 32'h1);
    wr(`TBC_ADDR_IRQ_ENABLE, 32'hff);
    rd(`TBC_ADDR_IRQ_ENABLE, 32'hbf);
  endtask
  task t_irq;
    src <= 5'h1f;
    wr(`TBC_ADDR_IRQ_ENABLE, 32'h3f);
    settle(1);
    chk({26'h0, irq_request}, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      wr(`TBC_ADDR_IRQ_ENABLE, 32'h80 | (32'h1 << k));
      settle(1);
      chk({26'h0, irq_request}, 32'h1 << k);
    end
    src <= 5'h00;
  endtask
  task t_timer;
    wr(`TBC_ADDR_RELOAD_LOW, 32'hfe);
    wr(`TBC_ADDR_RELOAD_HIGH, 32'hff);
    wr(`TBC_ADDR_COUNT_LOW, 32'hfe);
    wr(`TBC_ADDR_COUNT_HIGH, 32'hff);
    wr(`TBC_ADDR_IRQ_ENABLE, 32'ha0);
    settle(40);
    rd(`TBC_ADDR_CONTROL, 32'h00);
    // Two counts of twelve pclk each reach the rollover
    wr(`TBC_ADDR_CONTROL, 32'h04);
    settle(40);
    rd(`TBC_ADDR_CONTROL, 32'h84);
    settle(0);
    chk({31'h0, irq_request[5]}, 32'h1);
    wr(`TBC_ADDR_CONTROL, 32'h00);
    settle(1);
    chk({31'h0, irq_request[5]}, 32'h0);
  endtask
  task t_baud;
    // Timer is stopped while the reload pair is written
    wr(`TBC_ADDR_RELOAD_LOW, 32'hf0);
    wr(`TBC_ADDR_RELOAD_HIGH, 32'hff);
    wr(`TBC_ADDR_MODE, 32'h02);
    // Capture select set on purpose: baud mode must ignore it
    wr(`TBC_ADDR_CONTROL, 32'h1d);
    settle(1400);
    chk(tx_gap, 32 * (65536 - 32'hfff0));
    chk(clk_gap, 2 * (65536 - 32'hfff0));
    chk({31'h0, clk_oe}, 32'h1);
    chk(rx_count, 32'h0);
    chk({31'h0, irq_request[5]}, 32'h0);
    rd(`TBC_ADDR_CONTROL, 32'h1d);
    trig <= 1'b0;
    settle(10);
    rd(`TBC_ADDR_CONTROL, 32'h5d);
    rd(`TBC_ADDR_RELOAD_LOW, 32'hf0);
    settle(0);
    chk({31'h0, irq_request[5]}, 32'h1);
    settle(200);
    chk({31'h0, irq_request[5]}, 32'h1);
    wr(`TBC_ADDR_CONTROL, 32'h00);
    trig <= 1'b1;
    settle(1);
    chk({31'h0, irq_request[5]}, 32'h0);
    // Receive side alone: one tick lands inside the window, the second cannot yet
    wr(`TBC_ADDR_CONTROL, 32'h24);
    settle(700);
    chk(rx_count, 32'h1);
    chk(tx_gap, 32 * (65536 - 32'hfff0));
    wr(`TBC_ADDR_CONTROL, 32'h00);
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map;
    t_irq;
    t_timer;
    t_baud;
    end_sim;
  end
endmodule // tb
